/* rtl/ebrt_timer.sv */
// Decided for this implementation: the address-and-strobe port.
module ebrt_timer
	import ebrt_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic cpu_tick_pin,
	input wire logic hosc_tick_pin,
	input wire logic green_mode,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [7:0] rdata,
	input wire logic gpio_out,
	input wire logic gpio_oe,
	output logic shared_pulse_pin_out,
	output logic shared_pulse_pin_oe,
	output logic irq,
	output logic [7:0] irq_vector,
	output logic wake_req
);
	// ----------------------------------------
	// Registers and clock ticks
	// ----------------------------------------
	logic timer_run_enable_q;
	logic [2:0] prescale_select_q;
	logic clock_source_select_q;
	logic pulse_output_enable_q;
	logic [7:0] count_value_q;
	logic [7:0] reload_buffer_q;
	logic [7:0] reload_value_q;
	logic [7:0] duty_value_q;
	logic overflow_flag_q;
	logic overflow_interrupt_enable_q;
	logic pwm_level_q;
	logic cpu_tick;
	logic hosc_tick;
	logic div_tick;
	logic timer_tick;
	logic overflow;
	logic clear_ovf;

	ebrt_sync u_sync_cpu (
		.core_clk(core_clk),
		.reset(reset),
		.din(cpu_tick_pin),
		.dout(cpu_tick)
	);

	ebrt_sync u_sync_hosc (
		.core_clk(core_clk),
		.reset(reset),
		.din(hosc_tick_pin),
		.dout(hosc_tick)
	);

	ebrt_prescaler #(
		.WIDTH(EBRT_PRESCALE_WIDTH)
	) u_prescaler (
		.core_clk(core_clk),
		.reset(reset),
		.cpu_tick(cpu_tick),
		.rate(prescale_select_q),
		.tick(div_tick)
	);

	// The oscillator source ignores the prescaler setting entirely.
	assign timer_tick = timer_run_enable_q && (clock_source_select_q ? hosc_tick : div_tick);
	assign overflow = timer_tick && (count_value_q == EBRT_FULL_SCALE);
	assign clear_ovf = wr_en && (addr == EBRT_CLEAR_ADDR) && wdata[EBRT_OVF_BIT];

	// ----------------------------------------
	// Mode register
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			timer_run_enable_q <= 1'b0;
			prescale_select_q <= 3'h0;
			clock_source_select_q <= 1'b0;
			pulse_output_enable_q <= 1'b0;
		end else if (wr_en && addr == EBRT_MODE_ADDR) begin
			timer_run_enable_q <= wdata[EBRT_ENABLE_BIT];
			prescale_select_q <= wdata[EBRT_RATE_LSB +: 3];
			clock_source_select_q <= wdata[EBRT_CKSEL_BIT];
			pulse_output_enable_q <= wdata[EBRT_PWMEN_BIT];
		end
	end

	// ----------------------------------------
	// Counter with automatic reload
	// ----------------------------------------
	// A software write to the counter loses to any same-cycle tick: at overflow the reload wins,
	// otherwise the increment wins, so the period stays correct.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			count_value_q <= EBRT_RESET_VALUE;
		end else if (overflow) begin
			// The newest reload write must start the very next period, so load from the buffer.
			count_value_q <= reload_buffer_q;
		end else if (timer_tick) begin
			count_value_q <= count_value_q + 8'h01;
		end else if (wr_en && addr == EBRT_COUNT_ADDR) begin
			count_value_q <= wdata;
		end
	end

	// Double-buffered reload: while stopped a write lands directly so the first period is right.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			reload_buffer_q <= EBRT_RESET_VALUE;
			reload_value_q <= EBRT_RESET_VALUE;
		end else begin
			if (wr_en && addr == EBRT_RELOAD_ADDR) begin
				reload_buffer_q <= wdata;
				if (!timer_run_enable_q) begin
					reload_value_q <= wdata;
				end
			end
			if (overflow) begin
				reload_value_q <= reload_buffer_q;
			end
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			duty_value_q <= EBRT_RESET_VALUE;
		end else if (wr_en && addr == EBRT_DUTY_ADDR) begin
			duty_value_q <= wdata;
		end
	end

	// ----------------------------------------
	// Overflow flag and interrupt
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			overflow_flag_q <= 1'b0;
		end else if (overflow) begin
			overflow_flag_q <= 1'b1;
		end else if (clear_ovf) begin
			overflow_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			overflow_interrupt_enable_q <= 1'b0;
		end else if (wr_en && addr == EBRT_IRQEN_ADDR) begin
			overflow_interrupt_enable_q <= wdata[EBRT_OVF_BIT];
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			irq <= 1'b0;
			irq_vector <= 8'h00;
			wake_req <= 1'b0;
		end else begin
			irq <= overflow_interrupt_enable_q && (overflow_flag_q || overflow);
			irq_vector <= EBRT_VECTOR;
			wake_req <= 1'b0;
		end
	end

	// ----------------------------------------
	// PWM and shared pin
	// ----------------------------------------
	// Green mode does not gate anything here; the timer keeps running and never wakes.
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			pwm_level_q <= 1'b1;
		end else if (overflow) begin
			pwm_level_q <= 1'b1;
		end else if (timer_tick && (count_value_q + 8'h01) == duty_value_q) begin
			pwm_level_q <= 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			shared_pulse_pin_out <= 1'b0;
			shared_pulse_pin_oe <= 1'b0;
		end else if (pulse_output_enable_q && timer_run_enable_q) begin
			shared_pulse_pin_out <= pwm_level_q;
			shared_pulse_pin_oe <= 1'b1;
		end else begin
			shared_pulse_pin_out <= gpio_out;
			shared_pulse_pin_oe <= gpio_oe;
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			rdata <= 8'h00;
		end else if (rd_en) begin
			case (addr)
				EBRT_MODE_ADDR: rdata <= {timer_run_enable_q, prescale_select_q, 1'b0,
					clock_source_select_q, 1'b0, pulse_output_enable_q};
				EBRT_COUNT_ADDR: rdata <= count_value_q;
				EBRT_DUTY_ADDR: rdata <= duty_value_q;
				EBRT_STATUS_ADDR: rdata <= {7'h00, overflow_flag_q};
				EBRT_IRQEN_ADDR: rdata <= {7'h00, overflow_interrupt_enable_q};
				default: rdata <= 8'h00;
			endcase
		end else begin
			rdata <= 8'h00;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence roll_s;
		timer_tick && count_value_q == EBRT_FULL_SCALE;
	endsequence

	ovf_sets_flag_a: assert property (@(posedge core_clk) disable iff (reset)
		roll_s |=> overflow_flag_q) else $error("overflow did not set flag");
	flag_sticky_a: assert property (@(posedge core_clk) disable iff (reset)
		overflow_flag_q && !clear_ovf |=> overflow_flag_q) else $error("flag dropped");
	reload_load_a: assert property (@(posedge core_clk) disable iff (reset)
		roll_s |=> count_value_q == $past(reload_buffer_q)) else $error("no reload");
	stop_hold_a: assert property (@(posedge core_clk) disable iff (reset)
		!timer_run_enable_q && !wr_en |=> $stable(count_value_q)) else $error("counted stopped");
	count_step_a: assert property (@(posedge core_clk) disable iff (reset)
		timer_tick && count_value_q != EBRT_FULL_SCALE |=>
		count_value_q == $past(count_value_q) + 8'h01) else $error("bad step");
	irq_level_a: assert property (@(posedge core_clk) disable iff (reset)
		overflow_interrupt_enable_q && overflow_flag_q |=> irq) else $error("irq missing");
	no_wake_a: assert property (@(posedge core_clk) disable iff (reset)
		green_mode |-> !wake_req) else $error("woke system");
	pwm_high_a: assert property (@(posedge core_clk) disable iff (reset)
		roll_s |=> pwm_level_q) else $error("pwm not high at cycle start");
	pin_gpio_a: assert property (@(posedge core_clk) disable iff (reset)
		!pulse_output_enable_q |=> shared_pulse_pin_oe == $past(gpio_oe)) else $error("pin not gpio");
	hosc_path_a: assert property (@(posedge core_clk) disable iff (reset)
		timer_run_enable_q && clock_source_select_q && hosc_tick |-> timer_tick)
		else $error("oscillator tick lost");
endmodule : ebrt_timer

/* rtl/ebrt_pkg.sv */
// How it works
// - Enable bit gates counting on ticks.
// - Eight-bit counter steps once per tick.
// - Roll from full scale sets overflow flag.
// - Overflow flag stays until software clears.
// - Reload write waits for next overflow.
// - Reload always active while enabled.
// - Enabled overflow raises interrupt to vector.
// - Runs in green mode, never wakes.
// - Clock select picks divided or oscillator.
// - Prescale codes divide 128 down to 1.
// - Pulse enable hands pin to PWM while the run enable bit is set.
// - Mode register bit layout, reset zero.
// - Reload sets period, duty sets width.
// - High at start, low at duty match.
// - Disabling PWM restores GPIO, timer runs.
package ebrt_pkg;
	// ----------------------------------------
	// Register map (byte offsets on the plain port)
	// ----------------------------------------
	localparam logic [7:0] EBRT_MODE_ADDR = 8'hDC;
	localparam logic [7:0] EBRT_COUNT_ADDR = 8'hDD;
	localparam logic [7:0] EBRT_RELOAD_ADDR = 8'hDE;
	localparam logic [7:0] EBRT_DUTY_ADDR = 8'hEA;
	localparam logic [7:0] EBRT_STATUS_ADDR = 8'hE0;
	localparam logic [7:0] EBRT_CLEAR_ADDR = 8'hE1;
	localparam logic [7:0] EBRT_IRQEN_ADDR = 8'hE2;
	// ----------------------------------------
	// Fields
	// ----------------------------------------
	localparam int EBRT_ENABLE_BIT = 7;
	localparam int EBRT_RATE_LSB = 4;
	localparam int EBRT_CKSEL_BIT = 2;
	localparam int EBRT_PWMEN_BIT = 0;
	localparam logic [7:0] EBRT_MODE_MASK = 8'hF5;
	localparam int EBRT_OVF_BIT = 0;
	localparam logic [7:0] EBRT_RESET_VALUE = 8'h00;
	localparam logic [7:0] EBRT_FULL_SCALE = 8'hFF;
	localparam logic [7:0] EBRT_VECTOR = 8'h08;
	localparam int EBRT_PRESCALE_WIDTH = 7;
endpackage : ebrt_pkg

/* rtl/ebrt_sync.sv */
module ebrt_sync
	import ebrt_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic din,
	output logic dout
);
	logic meta_q;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			meta_q <= 1'b0;
			dout <= 1'b0;
		end else begin
			meta_q <= din;
			dout <= meta_q;
		end
	end
endmodule : ebrt_sync

/* rtl/ebrt_prescaler.sv */
// Free-running divider of the instruction clock strobe; one tick per selected division.
module ebrt_prescaler
	import ebrt_pkg::*;
#(
	parameter int WIDTH = EBRT_PRESCALE_WIDTH
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic cpu_tick,
	input wire logic [2:0] rate,
	output logic tick
);
	logic [WIDTH-1:0] div_q;
	logic [WIDTH-1:0] mask;

	initial begin
		if (WIDTH != 7) $error("prescaler must be 7 bits for a 128 divide");
	end

	// Code 000 divides by 128, code 111 by 1.
	assign mask = WIDTH'((8'h80 >> rate) - 8'h01);

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			div_q <= '0;
		end else if (cpu_tick) begin
			div_q <= div_q + 1'b1;
		end
	end

	assign tick = cpu_tick && ((div_q & mask) == mask);
endmodule : ebrt_prescaler

/* tb/eight_bit_reload_timer_pwm_bench.sv */
module eight_bit_reload_timer_pwm_bench
	import ebrt_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic cpu_tick = 1'b0;
	logic hosc_tick = 1'b0;
	logic green = 1'b0;
	logic wr_en = 1'b0;
	logic rd_en = 1'b0;
	logic gpio_out = 1'b0;
	logic gpio_oe = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rdata;
	logic [7:0] irq_vector;
	logic pin_out;
	logic pin_oe;
	logic irq;
	logic wake_req;
	logic rd_seen = 1'b0;
	logic [7:0] exp_q[$];
	logic [31:0] lfsr_q = 32'h00017E05;
	logic [7:0] r;
	logic [7:0] d;
	int err_count = 0;
	int cmp_count = 0;

	ebrt_timer uut (.core_clk(core_clk), .reset(reset), .cpu_tick_pin(cpu_tick),
		.hosc_tick_pin(hosc_tick), .green_mode(green), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
		.shared_pulse_pin_out(pin_out), .shared_pulse_pin_oe(pin_oe), .irq(irq),
		.irq_vector(irq_vector), .wake_req(wake_req));

	initial begin
		forever #5 core_clk = ~core_clk;
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] rnd();
		lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
		return lfsr_q[7:0];
	endfunction : rnd

	task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk_byte

	task automatic chk_bit(input logic got, input logic exp);
		chk_byte({7'h00, got}, {7'h00, exp});
	endtask : chk_bit

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		addr <= a;
		wdata <= v;
		wr_en <= 1'b1;
		@(posedge core_clk);
		wr_en <= 1'b0;
		@(posedge core_clk);
		// One more edge so outputs launched by the write have settled before any compare.
		@(posedge core_clk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		addr <= a;
		rd_en <= 1'b1;
		exp_q.push_back(e);
		@(posedge core_clk);
		rd_en <= 1'b0;
		@(posedge core_clk);
	endtask : rd

	// Strobes are spaced four cycles apart so the two-stage synchroniser sees each one.
	task automatic ticks(input logic src, input int n);
		repeat (n) begin
			if (src) hosc_tick <= 1'b1;
			else cpu_tick <= 1'b1;
			@(posedge core_clk);
			hosc_tick <= 1'b0;
			cpu_tick <= 1'b0;
			repeat (3) @(posedge core_clk);
		end
		repeat (4) @(posedge core_clk);
	endtask : ticks

	task automatic end_of_test();
		$display("errors=%0d compares=%0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : end_of_test

	// ----------------------------------------
	// Read data monitor
	// ----------------------------------------
	always @(posedge core_clk) begin
		if (rd_seen) begin
			if (exp_q.size() == 0) chk_byte(rdata, 8'hEE);
			else chk_byte(rdata, exp_q.pop_front());
		end
		rd_seen <= rd_en;
	end

	initial begin
		repeat (100000) @(posedge core_clk);
		err_count++;
		end_of_test();
	end

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge core_clk);
		reset <= 1'b0;
		repeat (2) @(posedge core_clk);
		chk_byte(irq_vector, EBRT_VECTOR);
		wr(8'h55, 8'hFF);
		rd(EBRT_MODE_ADDR, 8'h00);
		rd(8'h55, 8'h00);
		rd(EBRT_RELOAD_ADDR, 8'h00);
		wr(EBRT_MODE_ADDR, 8'h7F);
		rd(EBRT_MODE_ADDR, 8'h75);
		for (int c = 0; c < 8; c++) begin
			wr(EBRT_COUNT_ADDR, 8'h00);
			wr(EBRT_RELOAD_ADDR, 8'h00);
			wr(EBRT_MODE_ADDR, {1'b0, c[2:0], 4'h0});
			wr(EBRT_MODE_ADDR, {1'b1, c[2:0], 4'h0});
			ticks(1'b0, 128);
			wr(EBRT_MODE_ADDR, 8'h00);
			rd(EBRT_COUNT_ADDR, 8'h01 << c);
		end
		ticks(1'b0, 4);
		rd(EBRT_COUNT_ADDR, 8'h80);
		r = rnd() & 8'h7F;
		wr(EBRT_COUNT_ADDR, r);
		wr(EBRT_RELOAD_ADDR, r);
		wr(EBRT_MODE_ADDR, 8'h84);
		ticks(1'b1, 3);
		rd(EBRT_COUNT_ADDR, r + 8'h03);
		green <= 1'b1;
		wr(EBRT_COUNT_ADDR, 8'hFE);
		wr(EBRT_RELOAD_ADDR, 8'h30);
		rd(EBRT_COUNT_ADDR, 8'hFE);
		wr(EBRT_IRQEN_ADDR, 8'h01);
		ticks(1'b1, 1);
		rd(EBRT_STATUS_ADDR, 8'h00);
		chk_bit(irq, 1'b0);
		ticks(1'b1, 1);
		rd(EBRT_COUNT_ADDR, 8'h30);
		rd(EBRT_STATUS_ADDR, 8'h01);
		chk_bit(irq, 1'b1);
		chk_bit(wake_req, 1'b0);
		ticks(1'b1, 1);
		rd(EBRT_STATUS_ADDR, 8'h01);
		wr(EBRT_CLEAR_ADDR, 8'h01);
		rd(EBRT_STATUS_ADDR, 8'h00);
		chk_bit(irq, 1'b0);
		wr(EBRT_IRQEN_ADDR, 8'h00);
		wr(EBRT_COUNT_ADDR, 8'hFF);
		ticks(1'b1, 1);
		chk_bit(irq, 1'b0);
		wr(EBRT_IRQEN_ADDR, 8'h01);
		chk_bit(irq, 1'b1);
		wr(EBRT_CLEAR_ADDR, 8'h01);
		// Duty above reload, so the pulse has a visible high phase.
		d = 8'hF1 + (rnd() & 8'h07);
		gpio_oe <= 1'b1;
		gpio_out <= ^(rnd() & 8'h01);
		wr(EBRT_MODE_ADDR, 8'h05);
		wr(EBRT_DUTY_ADDR, d);
		wr(EBRT_COUNT_ADDR, 8'hF0);
		wr(EBRT_RELOAD_ADDR, 8'hF0);
		wr(EBRT_MODE_ADDR, 8'h85);
		chk_bit(pin_oe, 1'b1);
		ticks(1'b1, 16);
		chk_bit(pin_out, 1'b1);
		ticks(1'b1, int'(d - 8'hF0));
		chk_bit(pin_out, 1'b0);
		rd(EBRT_DUTY_ADDR, d);
		wr(EBRT_MODE_ADDR, 8'h84);
		chk_bit(pin_oe, gpio_oe);
		chk_bit(pin_out, gpio_out);
		ticks(1'b1, 2);
		rd(EBRT_COUNT_ADDR, d + 8'h02);
		repeat (4) @(posedge core_clk);
		end_of_test();
	end
endmodule : eight_bit_reload_timer_pwm_bench
